// [verilog/pixel_rop_consts.vh]
// constants of the per-plane pixel write datapath
`ifndef PIXEL_ROP_CONSTS_VH
`define PIXEL_ROP_CONSTS_VH

// register offsets, one 32-bit word each
`define RA_CTRL        8'h00
`define RA_COLOR       8'h04
`define RA_SEARCH      8'h08
`define RA_ACTIVITY    8'h0C
`define RA_AA_MIN      8'h10
`define RA_AA_MAX      8'h14
`define RA_SLOPE       8'h18
`define RA_POS         8'h1C
`define RA_STATUS      8'h20

// control register fields
`define CF_ROP_LSB     0
`define CF_MATCH       3
`define CF_SRC_INV     4
`define CF_SINGLE      5
`define CF_AA          6
`define CF_PEL         7
`define CF_CLS_LSB     8
`define CF_FP_LSB      12

// reset values
`define RV_CTRL        14'h0005
`define RV_NIBBLES     4'h0
`define RV_ACTIVITY    4'hF
`define RV_DIST        16'h0000
`define RV_SLOPE       12'h000
`define RV_POS         16'h0000
`define RV_CAND1       12'h001

// instruction classes
`define CLS_POINT      3'h0
`define CLS_LINE       3'h1
`define CLS_ARC        3'h2
`define CLS_CIRCLE     3'h3
`define CLS_FILL       3'h4
`define CLS_COPY       3'h5
`define CLS_STRING     3'h6

// anti-alias modes shown in status
`define AA_NONE        2'h0
`define AA_COMPARE     2'h1
`define AA_INVERSE     2'h2

// perpendicular position: integer pixel plus sixteenths
`define FRAC_W         4
`define POS_W          16
`define PIX_STEP       5'h10

`endif

// [verilog/pixel_raster_op_antialias.v]
// per-plane pixel write datapath: raster ops, match, source options, anti-alias
//
// Chosen here: strobed register access and the register offsets.
`include "pixel_rop_consts.vh"

// Overview of operation
// - maskless op 000 sets plotted pixel, clears other fifteen bits
// - maskless op 010 keeps plotted pixel, clears other fifteen bits
// - maskless op 001 writes one into plotted pixel, color ignored
// - maskless op 011 inverts destination pixel, color ignored
// - maskless op 100 writes zero per plane, color ignored
// - maskless op 101 writes plane color bit into plotted pixel
// - maskless op 110 ORs color bit into destination
// - maskless op 111 XORs color bit into destination
// - pattern element enabled: drawing uses its image as source operand
// - match enable writes only pixels whose full color equals search color; fills ignore it
// - for drawing, match enable counts only with pattern element enabled
// - source invert complements block copy source before the op
// - source invert in strings complements pattern words, not attribute
// - source invert in drawing complements pattern element
// - single plane source in copy replicates selected plane to all
// - single plane source in strings fetches and replicates selected plane
// - single plane source in drawing replicates selected pattern plane
// - anti-alias only suppresses plane write enables, values unchanged
// - each major step yields ideal perpendicular position in sixteenths
// - one or two nearest candidates, never beyond fifteen sixteenths
// - comparator writes plane when min <= distance <= max and active
// - inverse mode: all min MSBs one, all max MSBs zero
module pixel_raster_op_antialias
(
    input  wire        i_mclk,
    input  wire        i_arst_n,
    input  wire        i_ce,
    input  wire [7:0]  i_addr,
    input  wire [31:0] i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [31:0] o_rdata,
    input  wire        i_step,
    input  wire [2:0]  i_octant,
    input  wire        i_px_valid,
    input  wire        i_px_cand,
    input  wire        i_px_attr,
    input  wire [15:0] i_mask,
    input  wire [63:0] i_dst,
    input  wire [63:0] i_src,
    output reg         o_wr_valid,
    output reg  [63:0] o_wr_data,
    output reg  [3:0]  o_wr_en,
    output reg         o_major_y,
    output reg  [11:0] o_cand0,
    output reg  [11:0] o_cand1,
    output reg         o_cand_two,
    output reg  [3:0]  o_dist0,
    output reg  [3:0]  o_dist1
);

    reg  [13:0] ctrl_r;
    reg  [3:0]  color_r;
    reg  [3:0]  search_r;
    reg  [3:0]  activity_r;
    reg  [15:0] aa_min_r;
    reg  [15:0] aa_max_r;
    reg  [11:0] slope_r;
    reg  [15:0] pos_r;
    reg  [3:0]  last_en_r;

    wire [2:0]  rop       = ctrl_r[`CF_ROP_LSB +: 3];
    wire        match_en  = ctrl_r[`CF_MATCH];
    wire        src_inv   = ctrl_r[`CF_SRC_INV];
    wire        single    = ctrl_r[`CF_SINGLE];
    wire        aa_en     = ctrl_r[`CF_AA];
    wire        pel_en    = ctrl_r[`CF_PEL];
    wire [2:0]  cls       = ctrl_r[`CF_CLS_LSB +: 3];
    wire [1:0]  fp        = ctrl_r[`CF_FP_LSB +: 2];

    // one formula covers both op tables: with the interpolation mask as
    // source, the maskless behaviour falls out without a second table
    function [15:0] rop_word;
        input [2:0]  code;
        input        c;
        input [15:0] s;
        input [15:0] d;
        begin
            case (code)
                3'h0:    rop_word = s;
                3'h1:    rop_word = s | d;
                3'h2:    rop_word = s & d;
                3'h3:    rop_word = s ^ d;
                3'h4:    rop_word = ~s & d;
                3'h5:    rop_word = c ? (s | d) : (~s & d);
                3'h6:    rop_word = c ? (s | d) : d;
                default: rop_word = c ? (s ^ d) : d;
            endcase
        end
    endfunction

    // pixel positions where every plane, listening or not, equals search
    function [15:0] match_mask;
        input [63:0] d;
        input [3:0]  sc;
        integer      b;
        integer      q;
        begin
            match_mask = 16'hFFFF;
            for (b = 0; b < 16; b = b + 1)
            begin
                for (q = 0; q < 4; q = q + 1)
                begin
                    if (d[q*16 + b] != sc[q])
                    begin
                        match_mask[b] = 1'b0;
                    end
                end
            end
        end
    endfunction

    // anti-alias mode decode from distance programming
    reg         all_lt;
    reg         all_inv;
    reg  [1:0]  aa_mode;
    integer     m;

    always @*
    begin
        all_lt  = 1'b1;
        all_inv = 1'b1;
        for (m = 0; m < 4; m = m + 1)
        begin
            if (aa_min_r[m*4 +: 4] >= aa_max_r[m*4 +: 4])
            begin
                all_lt = 1'b0;
            end
            if (!aa_min_r[m*4 + 3] || aa_max_r[m*4 + 3])
            begin
                all_inv = 1'b0;
            end
        end
        // inverse programming has every min above every max, so the two
        // tests can never both hold
        if (all_inv)
        begin
            aa_mode = `AA_INVERSE;
        end
        else if (all_lt)
        begin
            aa_mode = `AA_COMPARE;
        end
        else
        begin
            // neither pattern programmed: anti-alias leaves every enable alone
            aa_mode = `AA_NONE;
        end
    end

    // instruction class decode
    wire is_draw  = (cls <= `CLS_CIRCLE);
    wire is_curve = (cls == `CLS_LINE) || (cls == `CLS_ARC) || (cls == `CLS_CIRCLE);
    wire use_pel  = is_draw && pel_en;
    wire use_mask = (is_draw && !pel_en) || (cls == `CLS_FILL);
    wire is_str   = (cls == `CLS_STRING);
    // fills carry no match bit; copy and string obey it always
    wire match_on = match_en && (is_draw ? pel_en :
                    ((cls == `CLS_COPY) || is_str));
    wire aa_on    = aa_en && is_curve;
    // attribute words are read only, so they never get an enable
    wire attr_px  = is_str && i_px_attr;

    // ideal position and its candidates
    wire [`FRAC_W-1:0] frac    = pos_r[`FRAC_W-1:0];
    wire [11:0]        pos_int = pos_r[`POS_W-1:`FRAC_W];
    // 16 - frac needs the fifth bit before it is cut back to four
    wire [4:0]         far_d   = `PIX_STEP - {1'b0, frac};
    // distance of whichever candidate the request names
    wire [3:0]         px_dist = i_px_cand ? o_dist1 : o_dist0;

    reg  [63:0] res_nxt;
    reg  [3:0]  en_nxt;
    reg  [15:0] s_word;
    reg  [15:0] d_word;
    reg  [15:0] r_word;
    reg  [15:0] mm;
    reg  [3:0]  inv_d;
    reg         aa_ok;
    integer     p;

    always @*
    begin
        res_nxt = 64'h0000_0000_0000_0000;
        en_nxt  = 4'h0;
        s_word  = 16'h0000;
        d_word  = 16'h0000;
        r_word  = 16'h0000;
        aa_ok   = 1'b1;
        mm      = match_mask(i_dst, search_r);
        inv_d   = ~px_dist;
        for (p = 0; p < 4; p = p + 1)
        begin
            d_word = i_dst[p*16 +: 16];
            if (use_mask)
            begin
                s_word = i_mask;
            end
            else
            begin
                if (single)
                begin
                    s_word = i_src[fp*16 +: 16];
                end
                else
                begin
                    s_word = i_src[p*16 +: 16];
                end
                if (src_inv && !attr_px)
                begin
                    s_word = ~s_word;
                end
            end
            r_word = rop_word(rop, color_r[p], s_word, d_word);
            if (match_on)
            begin
                r_word = (r_word & mm) | (d_word & ~mm);
            end
            res_nxt[p*16 +: 16] = r_word;
            aa_ok = 1'b1;
            if (aa_on)
            begin
                // values stay as computed; only the enable is gated
                if (aa_mode == `AA_COMPARE)
                begin
                    aa_ok = (px_dist >= aa_min_r[p*4 +: 4]) &&
                            (px_dist <= aa_max_r[p*4 +: 4]);
                end
                else if (aa_mode == `AA_INVERSE)
                begin
                    aa_ok = inv_d[3 - p];
                end
            end
            en_nxt[p] = activity_r[p] && aa_ok && !attr_px;
        end
    end

    // register writes
    always @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            ctrl_r     <= `RV_CTRL;
            color_r    <= `RV_NIBBLES;
            search_r   <= `RV_NIBBLES;
            activity_r <= `RV_ACTIVITY;
            aa_min_r   <= `RV_DIST;
            aa_max_r   <= `RV_DIST;
            slope_r    <= `RV_SLOPE;
        end
        else if (i_ce && i_wr)
        begin
            // status is read-only: a write to it takes the default arm
            case (i_addr)
                `RA_CTRL:     ctrl_r     <= i_wdata[13:0];
                `RA_COLOR:    color_r    <= i_wdata[3:0];
                `RA_SEARCH:   search_r   <= i_wdata[3:0];
                `RA_ACTIVITY: activity_r <= i_wdata[3:0];
                `RA_AA_MIN:   aa_min_r   <= i_wdata[15:0];
                `RA_AA_MAX:   aa_max_r   <= i_wdata[15:0];
                `RA_SLOPE:    slope_r    <= i_wdata[11:0];
                default:      ctrl_r     <= ctrl_r;
            endcase
        end
    end

    // ideal position walker; a position write beats a step in the same cycle
    always @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            pos_r      <= `RV_POS;
            o_major_y  <= 1'b0;
            o_cand0    <= 12'h000;
            // cand1 always sits one above cand0, reset included
            o_cand1    <= `RV_CAND1;
            o_cand_two <= 1'b0;
            o_dist0    <= 4'h0;
            o_dist1    <= 4'h0;
        end
        else if (i_ce)
        begin
            if (i_wr && (i_addr == `RA_POS))
            begin
                pos_r <= i_wdata[15:0];
            end
            else if (i_step)
            begin
                // slope is signed sixteenths, sign extended to the 12.4 width
                pos_r     <= pos_r + {{4{slope_r[11]}}, slope_r};
            end
            // the axis follows every step, even one whose position write wins
            if (i_step)
            begin
                o_major_y <= i_octant[0] ^ i_octant[1];
            end
            // cand0 sits frac away, cand1 sits 16 - frac away,
            // so no candidate is ever more than 15/16 off
            o_cand0    <= pos_int;
            o_cand1    <= pos_int + 12'h001;
            o_cand_two <= (frac != 4'h0);
            o_dist0    <= frac;
            o_dist1    <= (frac != 4'h0) ? far_d[3:0] : 4'h0;
        end
    end

    // pixel result stage
    always @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_wr_valid <= 1'b0;
            o_wr_data  <= 64'h0000_0000_0000_0000;
            o_wr_en    <= 4'h0;
            last_en_r  <= 4'h0;
        end
        else if (i_ce)
        begin
            o_wr_valid <= i_px_valid;
            if (i_px_valid)
            begin
                o_wr_data <= res_nxt;
                o_wr_en   <= en_nxt;
                // kept for status, so software can see what anti-alias dropped
                last_en_r <= en_nxt;
            end
            else
            begin
                // enables last one cycle; data holds for the memory side
                o_wr_en <= 4'h0;
            end
        end
    end

    // read data, one cycle after the strobe and only then
    always @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_rdata <= 32'h0000_0000;
        end
        else if (i_ce)
        begin
            if (i_rd)
            begin
                case (i_addr)
                    `RA_CTRL:     o_rdata <= {18'h0_0000, ctrl_r};
                    `RA_COLOR:    o_rdata <= {28'h000_0000, color_r};
                    `RA_SEARCH:   o_rdata <= {28'h000_0000, search_r};
                    `RA_ACTIVITY: o_rdata <= {28'h000_0000, activity_r};
                    `RA_AA_MIN:   o_rdata <= {16'h0000, aa_min_r};
                    `RA_AA_MAX:   o_rdata <= {16'h0000, aa_max_r};
                    `RA_SLOPE:    o_rdata <= {20'h0_0000, slope_r};
                    `RA_POS:      o_rdata <= {16'h0000, pos_r};
                    `RA_STATUS:   o_rdata <= {23'h00_0000, o_cand_two,
                                              last_en_r, 2'h0, aa_mode};
                    default:      o_rdata <= 32'h0000_0000;
                endcase
            end
            else
            begin
                o_rdata <= 32'h0000_0000;
            end
        end
    end

endmodule

// [test/raster_chk_sva.sv]
// assertions on the ports of the pixel write datapath
module raster_chk
(
    input logic        i_mclk,
    input logic        i_arst_n,
    input logic        i_ce,
    input logic        i_rd,
    input logic        i_px_valid,
    input logic        i_step,
    input logic [2:0]  i_octant,
    input logic [31:0] o_rdata,
    input logic        o_wr_valid,
    input logic [63:0] o_wr_data,
    input logic [3:0]  o_wr_en,
    input logic        o_major_y,
    input logic [11:0] o_cand0,
    input logic [11:0] o_cand1,
    input logic        o_cand_two,
    input logic [3:0]  o_dist0,
    input logic [3:0]  o_dist1
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);
    a_wr_follows:
    assert property (i_ce && i_px_valid |=> o_wr_valid) else $error("write result missing");
    a_no_stray_write:
    assert property (i_ce && !i_px_valid |=> !o_wr_valid && o_wr_en == 4'h0)
        else $error("write enable without request");
    a_data_holds:
    assert property (i_ce && !i_px_valid |=> $stable(o_wr_data)) else $error("data moved");
    a_rd_window:
    assert property (i_ce && !i_rd |=> o_rdata == 32'h0000_0000) else $error("stray read data");
    a_major_axis:
    assert property (i_ce && i_step |=> o_major_y == ($past(i_octant[0]) ^ $past(i_octant[1])))
        else $error("major axis wrong");
    a_cand_pair:
    assert property (o_cand1 == o_cand0 + 12'h001) else $error("candidates not adjacent");
    a_dist_span:
    assert property (o_cand_two |-> {1'b0, o_dist0} + {1'b0, o_dist1} == 5'h10)
        else $error("distances do not span one pixel");
    a_one_cand:
    assert property (!o_cand_two |-> o_dist0 == 4'h0 && o_dist1 == 4'h0)
        else $error("single candidate with distance");
    c_pixel: cover property (i_px_valid ##1 o_wr_valid && o_wr_en != 4'hF);
    c_two: cover property (o_cand_two ##1 !o_cand_two);
    c_step: cover property (i_step && i_octant[0]);
endmodule

bind pixel_raster_op_antialias raster_chk u_chk (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_rd(i_rd),
    .i_px_valid(i_px_valid), .i_step(i_step), .i_octant(i_octant), .o_rdata(o_rdata),
    .o_wr_valid(o_wr_valid), .o_wr_data(o_wr_data), .o_wr_en(o_wr_en),
    .o_major_y(o_major_y), .o_cand0(o_cand0), .o_cand1(o_cand1),
    .o_cand_two(o_cand_two), .o_dist0(o_dist0), .o_dist1(o_dist1));

// [test/draw_host.sv]
// host model: register writes and reads toward the pixel datapath
module draw_host
(
    input  logic        i_mclk,
    input  logic [31:0] i_rdata,
    output logic [7:0]  o_addr,
    output logic [31:0] o_wdata,
    output logic        o_wr,
    output logic        o_rd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {o_addr, o_wdata, o_wr, o_rd} = '0;
    // idle edge after each strobe, so back-to-back calls never drive a strobe twice
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_mclk);
        o_wr <= 1'b0;
        @(posedge i_mclk);
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_mclk);
        o_rd <= 1'b0;
        #1 d = i_rdata;
        @(posedge i_mclk);
    endtask
    // comparator: every min below its max; inverse: min msbs set, max msbs clear
    task automatic set_dist(input logic [15:0] mn, input logic [15:0] mx);
        wr_reg(8'h10, {16'h0000, mn});
        wr_reg(8'h14, {16'h0000, mx});
    endtask
endmodule

// [test/pixel_raster_op_antialias_test.sv]
// testbench: pixel write datapath driven through the host model
`include "pixel_rop_consts.vh"
module pixel_raster_op_antialias_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0;
    logic        arst_n = 1'b0;
    logic        step = 1'b0;
    logic        ce = 1'b1;
    logic [2:0]  octant = 3'h0;
    logic        pxv = 1'b0;
    logic        cand = 1'b0;
    logic        attr = 1'b0;
    logic [15:0] mask = 16'h0000;
    logic [63:0] dst = '0;
    logic [63:0] src = '0;
    logic [31:0] rdata, wdata, rv;
    logic [7:0]  addr;
    logic        wr, rd, wv, mj, two;
    logic [63:0] wd;
    logic [3:0]  we, d0, d1;
    logic [11:0] c0, c1;
    int          n_errors = 0;
    int          samples_checked = 0;

    always #2 mclk = ~mclk;

    draw_host HOST (.i_mclk(mclk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
        .o_wr(wr), .o_rd(rd));
    pixel_raster_op_antialias DUT (.i_mclk(mclk), .i_arst_n(arst_n), .i_ce(ce),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_step(step), .i_octant(octant), .i_px_valid(pxv), .i_px_cand(cand),
        .i_px_attr(attr), .i_mask(mask), .i_dst(dst), .i_src(src), .o_wr_valid(wv),
        .o_wr_data(wd), .o_wr_en(we), .o_major_y(mj), .o_cand0(c0), .o_cand1(c1),
        .o_cand_two(two), .o_dist0(d0), .o_dist1(d1));

    task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
        samples_checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    // reference result per plane word, written out from the maskless op table
    function automatic logic [15:0] rop(input logic [2:0] op, input logic c,
                                       input logic [15:0] m, input logic [15:0] d);
        logic [15:0] hit;
        case (op)
            3'h0, 3'h1: hit = 16'hFFFF;
            3'h2: hit = d;
            3'h3: hit = ~d;
            3'h4: hit = 16'h0000;
            3'h5: hit = {16{c}};
            3'h6: hit = d | {16{c}};
            default: hit = d ^ {16{c}};
        endcase
        // codes 000 and 010 also clear every pixel off the mask
        rop = (hit & m) | ((op == 3'h0 || op == 3'h2) ? 16'h0000 : (d & ~m));
    endfunction

    task automatic px(input logic [15:0] m, input logic [63:0] d, input logic [63:0] s,
                      input logic c, input logic a, input logic [63:0] ed, input logic [3:0] ee);
        mask <= m;
        dst <= d;
        src <= s;
        cand <= c;
        attr <= a;
        pxv <= 1'b1;
        @(posedge mclk);
        pxv <= 1'b0;
        #1 chk(64'(wv), 64'h1, "valid");
        chk(64'(we), 64'(ee), "enables");
        // data of a refused attribute word is of no interest
        if (!a)
            chk(wd, ed, "data");
        @(posedge mclk);
    endtask

    task automatic t_regs;
        HOST.rd_reg(`RA_CTRL, rv);
        chk(64'(rv), 64'h0005, "ctrl reset");
        HOST.rd_reg(`RA_ACTIVITY, rv);
        chk(64'(rv), 64'h000F, "activity reset");
        HOST.rd_reg(8'hFC, rv);
        chk(64'(rv), 64'h0000, "unmapped read");
        HOST.wr_reg(`RA_COLOR, 32'h0000_0005);
        HOST.rd_reg(`RA_COLOR, rv);
        chk(64'(rv), 64'h0005, "color");
        $display("test regs done");
    endtask

    // color 5: planes 0 and 2 see a one, planes 1 and 3 a zero
    task automatic t_ops;
        logic [63:0] e;
        for (int op = 0; op < 8; op++)
        begin
            // odd codes run as a fill, which takes the mask as source too
            HOST.wr_reg(`RA_CTRL, 32'(op) | (op[0] ? 32'h0000_0400 : 32'h0000_0000));
            for (int p = 0; p < 4; p++)
                e[p*16 +: 16] = rop(3'(op), !p[0], 16'h0011, 16'h00F0);
            px(16'h0011, {4{16'h00F0}}, '0, 1'b0, 1'b0, e,
               4'hF);
        end
        $display("test ops done");
    endtask

    task automatic t_source;
        logic [63:0] s;
        s = 64'h1234_5678_9ABC_DEF0;
        HOST.wr_reg(`RA_CTRL, 32'h0000_0081);
        px(16'h0001, {4{16'h0F00}}, s, 1'b0, 1'b0, s | {4{16'h0F00}}, 4'hF);
        HOST.wr_reg(`RA_CTRL, 32'h0000_20B0);
        px(16'h0001, '0, s, 1'b0, 1'b0, {4{16'hA987}}, 4'hF);
        HOST.wr_reg(`RA_CTRL, 32'h0000_0510);
        px(16'h0001, '0, s, 1'b0, 1'b0, ~s, 4'hF);
        HOST.wr_reg(`RA_CTRL, 32'h0000_1520);
        px(16'h0001, '0, s, 1'b0, 1'b0, {4{16'h9ABC}}, 4'hF);
        HOST.wr_reg(`RA_CTRL, 32'h0000_2630);
        px(16'h0001, '0, s, 1'b0, 1'b0, {4{16'hA987}}, 4'hF);
        px(16'h0001, '0, s, 1'b0, 1'b1, '0, 4'h0);
        $display("test source done");
    endtask

    // pixel 0 has color 3 over planes 0 and 1, the rest color 0
    task automatic t_match;
        HOST.wr_reg(`RA_SEARCH, 32'h0000_0003);
        HOST.wr_reg(`RA_ACTIVITY, 32'h0000_0003);
        HOST.wr_reg(`RA_CTRL, 32'h0000_0088);
        px(16'h0003, {32'h0, {2{16'h0001}}}, '1, 1'b0, 1'b0, {4{16'h0001}},
           4'h3);
        HOST.wr_reg(`RA_ACTIVITY, 32'h0000_000F);
        HOST.wr_reg(`RA_CTRL, 32'h0000_0009);
        px(16'h0003, {32'h0, {2{16'h0001}}}, '0, 1'b0, 1'b0, {4{16'h0003}}, 4'hF);
        $display("test match done");
    endtask

    task automatic t_walk;
        HOST.wr_reg(`RA_SLOPE, 32'h0000_000D);
        HOST.wr_reg(`RA_POS, 32'h0000_0023);
        octant <= 3'h1;
        step <= 1'b1;
        #1 chk(64'({c0, c1, 3'h0, two, d0, d1}), 64'h0_0200_313D,
               "two candidates");
        @(posedge mclk);
        step <= 1'b0;
        @(posedge mclk);
        #1 chk(64'({3'h0, mj, c0, c1, 3'h0, two, d0, d1}), 64'h10_0300_4000,
               "one candidate");
        // a low clock enable must swallow a step
        @(posedge mclk);
        ce <= 1'b0;
        step <= 1'b1;
        @(posedge mclk);
        ce <= 1'b1;
        step <= 1'b0;
        @(posedge mclk);
        #1 chk(64'({c0, 3'h0, two, d0}), 64'h0_0300, "clock enable freeze");
        @(posedge mclk);
        $display("test walk done");
    endtask

    // op 101 on a black word: planes with color one get the pixel
    task automatic t_alias;
        HOST.wr_reg(`RA_POS, 32'h0000_0023);
        HOST.set_dist(16'h0000, 16'hFDB7);
        HOST.wr_reg(`RA_CTRL, 32'h0000_0145);
        px(16'h0001, '0, '0, 1'b0, 1'b0, 64'h0000_0001_0000_0001, 4'hF);
        // same op as an arc, then the inverse pattern as a circle
        HOST.wr_reg(`RA_CTRL, 32'h0000_0245);
        px(16'h0001, '0, '0, 1'b1, 1'b0, 64'h0000_0001_0000_0001, 4'hC);
        HOST.set_dist(16'h8888, 16'h0000);
        HOST.wr_reg(`RA_CTRL, 32'h0000_0345);
        px(16'h0001, '0, '0, 1'b0, 1'b0, 64'h0000_0001_0000_0001, 4'h3);
        px(16'h0001, '0, '0, 1'b1, 1'b0, 64'h0000_0001_0000_0001, 4'h4);
        HOST.wr_reg(`RA_CTRL, 32'h0000_0045);
        px(16'h0001, '0, '0, 1'b1, 1'b0, 64'h0000_0001_0000_0001, 4'hF);
        $display("test alias done");
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // whole run is well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        end_sim;
    end

    initial
    begin
        repeat (10) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        t_regs;
        t_ops;
        t_source;
        t_match;
        t_walk;
        t_alias;
        end_sim;
    end
endmodule
